//--- rtl/loop_regs.svh
// Register offset, field codes, reset values and timing counts of the process loop.
// Assumes it is included by bare name; it holds definitions only.
`ifndef LOOP_REGS_SVH
`define LOOP_REGS_SVH
`define REG_FEEDBACK_ADDR   16'h0006
`define FEEDBACK_RESET      16'h0000
`define PCT_FULL            16'h2710
`define LEVEL_TO_PCT        16'h000a
`define FSRC_TERMINAL       8'h01
`define FSRC_ARITH          8'h10
`define FB_SRC_ANALOG       8'h01
`define FB_SRC_BUS          8'h02
`define FB_SRC_ARITH        8'h10
`define REVERSE_ON          2'h1
`define GAIN_MIN_PCT        7'h14
`define GAIN_MAX_PCT        7'h64
`define WAKE_MAX_CHZ        16'h9c40
`define ACC_LIMIT           32'sh10000000
`define CLK_PERIOD_NS       10
`define TICK_PERIOD_US      1000
`define TICK_CYC            (`TICK_PERIOD_US * 1000 / `CLK_PERIOD_NS)
`define DELAY_UNIT_US       100000
`define TICKS_PER_DELAY     (`DELAY_UNIT_US / `TICK_PERIOD_US)
`endif

//--- rtl/loop_pkg.sv
// Types shared by the process loop modules.
// Assumes nothing of its surroundings.
package loop_pkg;
  typedef enum logic [1:0] {
    LOOP_OFF    = 2'b00,
    LOOP_NORMAL = 2'b01,
    LOOP_INVERT = 2'b10
  } loop_mode_t;
  typedef enum logic {
    AWAKE  = 1'b0,
    ASLEEP = 1'b1
  } sleep_state_t;
endpackage : loop_pkg

//--- rtl/sat_clamp.sv
// Signed saturating limiter between a lower and an upper bound.
// Assumes lo is not above hi; purely combinational.
`timescale 1ns/1ps
module sat_clamp #(
  parameter int W = 18
) (
  input  wire logic signed [W-1:0] value,
  input  wire logic signed [W-1:0] lo,
  input  wire logic signed [W-1:0] hi,
  output logic signed [W-1:0]      clamped
);
  // If the bounds cross, values below lo give lo and all others give hi, so a bad setting still gives a defined value.
  assign clamped = (value < lo) ? lo : ((value > hi) ? hi : value);
endmodule : sat_clamp

//--- rtl/hold_timer.sv
// Qualifying delay: counts sample ticks while a condition holds.
// Assumes tick is a one-cycle pulse from the loop's sample divider.
`timescale 1ns/1ps
module hold_timer (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        cond,
  input  wire logic [14:0] limit,
  output logic             done
);
  logic [14:0] count_r;

  // Any drop of the condition restarts the wait, so a brief excursion never fires.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_r <= 15'h0000;
    end else if (!cond) begin
      count_r <= 15'h0000;
    end else if (tick && (count_r < limit)) begin
      count_r <= count_r + 15'h0001;
    end
  end

  // A zero limit fires as soon as the condition is seen.
  assign done = cond && (count_r >= limit);

  // The count is cleared right after the condition drops.
  cancel_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    !cond |=> count_r == 15'h0000)
    else $error("hold timer kept counting without condition");
  // The count never runs past its limit.
  count_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
    $stable(limit) |=> count_r <= limit || $past(count_r) > limit)
    else $error("hold timer overran its limit");
endmodule : hold_timer

//--- rtl/drive_pid_process_controller.sv
// Process loop of the drive: target, feedback, PID command, clamps, sleep and flags.
// Assumes settings are static between ticks and bus strobes are one-cycle pulses.
`timescale 1ns/1ps
`include "loop_regs.svh"
module drive_pid_process_controller
  import loop_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [15:0] bus_addr,
  input  wire logic [15:0] bus_wdata,
  output logic [15:0]      bus_rdata_r,
  output logic             bus_ack_r,
  output logic             bus_nak_r,
  input  wire logic [7:0]  frequency_source_select,
  input  wire logic [15:0] target_preset,
  input  wire logic [15:0] target_analog,
  input  wire logic [15:0] arith_result,
  input  wire logic [15:0] analog_feedback_input,
  input  wire logic [7:0]  feedback_source_select,
  input  wire logic [1:0]  loop_enable_mode,
  input  wire logic        loop_inhibit,
  input  wire logic [7:0]  prop_gain,
  input  wire logic [15:0] integral_time,
  input  wire logic [9:0]  derivative_time,
  input  wire logic [13:0] feedback_scale,
  input  wire logic [1:0]  reverse_action,
  input  wire logic [9:0]  variation_range,
  input  wire logic [15:0] max_frequency,
  input  wire logic [11:0] sleep_threshold,
  input  wire logic [7:0]  sleep_delay,
  input  wire logic [15:0] wake_threshold,
  input  wire logic [9:0]  deviation_level,
  input  wire logic [9:0]  window_off_level,
  input  wire logic [9:0]  window_on_level,
  input  wire logic [6:0]  voltage_gain_pct,
  input  wire logic [8:0]  regulated_voltage_select,
  output logic [15:0]      command_pct_r,
  output logic [15:0]      frequency_command_r,
  output logic             output_stopped_r,
  output logic [23:0]      feedback_monitor_r,
  output logic             deviation_exceeded_flag_r,
  output logic             feedback_window_flag_r,
  output logic [15:0]      output_voltage_r
);
  logic [16:0]         tick_cnt_r;
  logic                tick_r;
  logic [15:0]         loop_feedback_value_r;
  logic signed [17:0]  err_prev_r;
  logic signed [31:0]  acc_r;
  sleep_state_t        state_r;
  logic [15:0]         target;
  logic [15:0]         fb_bus;
  logic [15:0]         fb;
  logic signed [17:0]  err_raw;
  logic signed [17:0]  err;
  logic signed [17:0]  abs_err;
  logic signed [17:0]  de;
  logic signed [47:0]  kp48;
  logic signed [47:0]  p_t;
  logic signed [47:0]  i_t;
  logic signed [47:0]  d_t;
  logic signed [47:0]  sum48;
  logic signed [47:0]  lim_hi;
  logic signed [47:0]  pid48;
  logic signed [17:0]  pid18;
  logic signed [17:0]  span18;
  logic signed [17:0]  tgt18;
  logic signed [17:0]  var18;
  logic signed [17:0]  shaped;
  logic                var_on;
  logic                loop_run;
  loop_mode_t          mode;
  logic [15:0]         pct_loop;
  logic [15:0]         pct_nxt;
  logic signed [31:0]  acc_nxt;
  logic [15:0]         freq_now;
  logic [15:0]         sleep_chz;
  logic [15:0]         wake_eff;
  logic                sleep_done;
  logic                wake_done;
  logic [14:0]         delay_ticks;
  logic [6:0]          gain_eff;
  logic                fb_hit;

  // Sample divider: the PID command, integrator and flags move only on this pulse.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt_r <= 17'h00000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r >= 17'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 17'h00000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h00001;
      tick_r     <= 1'b0;
    end
  end

  // Target and feedback selection.
  assign target = (frequency_source_select == `FSRC_TERMINAL) ? target_analog :
                  (frequency_source_select == `FSRC_ARITH) ? arith_result :
                  target_preset;
  // Out-of-range bus values are held at full scale rather than wrapping.
  assign fb_bus = (loop_feedback_value_r > `PCT_FULL) ? `PCT_FULL
                                                      : loop_feedback_value_r;
  assign fb = (feedback_source_select == `FB_SRC_ANALOG) ? analog_feedback_input :
              (feedback_source_select == `FB_SRC_BUS) ? fb_bus :
              (feedback_source_select == `FB_SRC_ARITH) ? arith_result :
              16'h0000;

  // Deviation with optional polarity reversal.
  assign err_raw = $signed({2'b00, target}) - $signed({2'b00, fb});
  assign err     = (reverse_action == `REVERSE_ON) ? -err_raw : err_raw;
  assign abs_err = err[17] ? -err : err;
  assign de      = err - err_prev_r;

  // PID terms in 0.01 percent; gains in 0.1 steps, times in 0.1 s steps.
  assign kp48  = 48'(prop_gain);
  assign p_t   = (kp48 * 48'(err)) / 48'sha;
  assign i_t   = (integral_time == 16'h0000) ? 48'sh0 :
                 (kp48 * 48'(acc_r)) / $signed(48'(integral_time) * 48'sh3e8);
  assign d_t   = kp48 * 48'(derivative_time) * 48'(de) * 48'sha;
  assign sum48 = p_t + i_t + d_t;

  // PCT_FULL bounds the raw sum to plus or minus full scale.
  assign lim_hi = 48'(`PCT_FULL);
  sat_clamp #(
    .W(48)
  ) u_full_clamp (
    .value   (sum48),
    .lo      (-lim_hi),
    .hi      (lim_hi),
    .clamped (pid48)
  );
  assign pid18 = pid48[17:0];

  // Variation window around the target.
  assign span18 = 18'(variation_range) * 18'sha;
  assign tgt18  = 18'(target);
  sat_clamp #(
    .W(18)
  ) u_var_clamp (
    .value   (pid18),
    .lo      (tgt18 - span18),
    .hi      (tgt18 + span18),
    .clamped (var18)
  );
  assign mode   = loop_mode_t'(loop_enable_mode);
  assign var_on = (variation_range != 10'h000) && (mode != LOOP_INVERT);
  assign shaped = var_on ? var18 : pid18;

  // Negative results: zero in normal mode, sign flipped in inverted mode.
  always_comb begin
    pct_loop = 16'(shaped);
    if (shaped < 18'sh00000) begin
      if (mode == LOOP_INVERT) begin
        pct_loop = 16'(-shaped);
      end else begin
        pct_loop = 16'h0000;
      end
    end
  end

  // Code 11 is not a mode and is treated as off.
  always_comb begin
    unique case (mode)
      LOOP_NORMAL: loop_run = !loop_inhibit;
      LOOP_INVERT: loop_run = !loop_inhibit;
      default:     loop_run = 1'b0;
    endcase
  end
  assign pct_nxt = loop_run ? pct_loop : target;

  // Integrator with clamp; a hard limit stops wind-up from overflowing the term.
  always_comb begin
    acc_nxt = acc_r + 32'(err);
    if (acc_nxt > `ACC_LIMIT) begin
      acc_nxt = `ACC_LIMIT;
    end else if (acc_nxt < -`ACC_LIMIT) begin
      acc_nxt = -`ACC_LIMIT;
    end
  end

  // Loop state, updated once per tick.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      command_pct_r <= 16'h0000;
      err_prev_r    <= 18'sh00000;
      acc_r         <= 32'sh00000000;
    end else if (tick_r) begin
      command_pct_r <= pct_nxt;
      err_prev_r    <= err;
      // The integrator is dropped while the loop is idle to avoid a surge on re-entry.
      acc_r         <= loop_run ? acc_nxt : 32'sh00000000;
    end
  end

  // Deviation and feedback-window flags with the monitor value.
  assign fb_hit = fb > (16'(window_on_level) * `LEVEL_TO_PCT);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      deviation_exceeded_flag_r <= 1'b0;
      feedback_window_flag_r    <= 1'b0;
      feedback_monitor_r        <= 24'h000000;
    end else if (tick_r) begin
      deviation_exceeded_flag_r <=
        abs_err > 18'(16'(deviation_level) * `LEVEL_TO_PCT);
      if (fb_hit) begin
        feedback_window_flag_r <= 1'b1;
      end else if (fb < (16'(window_off_level) * `LEVEL_TO_PCT)) begin
        feedback_window_flag_r <= 1'b0;
      end
      feedback_monitor_r <= 24'((30'(fb) * 30'(feedback_scale)) / 30'h64);
    end
  end

  // Command in 0.01 Hz; thresholds scaled into the same unit.
  assign freq_now    = 16'((32'(command_pct_r) * 32'(max_frequency)) / 32'(`PCT_FULL));
  assign sleep_chz   = 16'(sleep_threshold) * `LEVEL_TO_PCT;
  assign wake_eff    = (wake_threshold < sleep_chz) ? sleep_chz :
                       (wake_threshold > `WAKE_MAX_CHZ) ? `WAKE_MAX_CHZ :
                       wake_threshold;
  assign delay_ticks = 15'(sleep_delay) * 15'(`TICKS_PER_DELAY);

  hold_timer u_sleep_wait (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (tick_r),
    .cond  ((state_r == AWAKE) && (freq_now < sleep_chz)),
    .limit (delay_ticks),
    .done  (sleep_done)
  );
  hold_timer u_wake_wait (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (tick_r),
    .cond  ((state_r == ASLEEP) && (freq_now > wake_eff)),
    .limit (delay_ticks),
    .done  (wake_done)
  );

  // Sleep state machine; the timers cancel themselves when the level recovers.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= AWAKE;
    end else begin
      unique case (state_r)
        AWAKE:  if (sleep_done) state_r <= ASLEEP;
        ASLEEP: if (wake_done) state_r <= AWAKE;
      endcase
    end
  end

  // Delivered frequency and stop indication.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      frequency_command_r <= 16'h0000;
      output_stopped_r    <= 1'b0;
    end else begin
      frequency_command_r <= (state_r == ASLEEP) ? 16'h0000 : freq_now;
      output_stopped_r    <= (state_r == ASLEEP);
    end
  end

  // Output voltage; gain outside 20..100 is pinned to the nearest end.
  assign gain_eff = (voltage_gain_pct < `GAIN_MIN_PCT) ? `GAIN_MIN_PCT :
                    (voltage_gain_pct > `GAIN_MAX_PCT) ? `GAIN_MAX_PCT :
                    voltage_gain_pct;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      output_voltage_r <= 16'h0000;
    end else begin
      output_voltage_r <=
        (16'(regulated_voltage_select) * 16'(gain_eff)) / 16'(`GAIN_MAX_PCT);
    end
  end

  // Feedback register port: writes always land, reads only with bus feedback.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      loop_feedback_value_r <= `FEEDBACK_RESET;
      bus_rdata_r           <= 16'h0000;
      bus_ack_r             <= 1'b0;
      bus_nak_r             <= 1'b0;
    end else begin
      bus_ack_r <= 1'b0;
      bus_nak_r <= 1'b0;
      if (bus_wr) begin
        if (bus_addr == `REG_FEEDBACK_ADDR) begin
          loop_feedback_value_r <= bus_wdata;
          bus_ack_r             <= 1'b1;
        end else begin
          bus_nak_r <= 1'b1;
        end
      end else if (bus_rd) begin
        if ((bus_addr == `REG_FEEDBACK_ADDR) &&
            (feedback_source_select == `FB_SRC_BUS)) begin
          bus_rdata_r <= loop_feedback_value_r;
          bus_ack_r   <= 1'b1;
        end else begin
          bus_rdata_r <= 16'h0000;
          bus_nak_r   <= 1'b1;
        end
      end
    end
  end

  // Checks on the loop outputs.
  read_refused_a: assert property (@(posedge clock) disable iff (!rst_n)
    bus_rd && !bus_wr && (feedback_source_select != `FB_SRC_BUS)
    |=> bus_nak_r && !bus_ack_r && bus_rdata_r == 16'h0000)
    else $error("feedback read served with non-bus source");
  read_served_a: assert property (@(posedge clock) disable iff (!rst_n)
    bus_rd && !bus_wr && bus_addr == `REG_FEEDBACK_ADDR &&
    feedback_source_select == `FB_SRC_BUS
    |=> bus_ack_r && bus_rdata_r == $past(loop_feedback_value_r))
    else $error("feedback read returned wrong data");
  write_store_a: assert property (@(posedge clock) disable iff (!rst_n)
    bus_wr && bus_addr == `REG_FEEDBACK_ADDR
    |=> loop_feedback_value_r == $past(bus_wdata) && bus_ack_r)
    else $error("feedback write not stored");
  open_loop_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick_r && (loop_inhibit || mode == LOOP_OFF) |=> command_pct_r == $past(target))
    else $error("open-loop command differs from target");
  neg_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick_r && mode == LOOP_NORMAL && !loop_inhibit && shaped < 18'sh00000
    |=> command_pct_r == 16'h0000)
    else $error("negative result not held at zero");
  neg_invert_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick_r && mode == LOOP_INVERT && !loop_inhibit && pid18 < 18'sh00000
    |=> command_pct_r == 16'($past(-pid18)))
    else $error("negative result not inverted");
  var_window_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick_r && mode == LOOP_NORMAL && !loop_inhibit && variation_range != 10'h000
    |=> 18'(command_pct_r) <= $past(tgt18 + span18))
    else $error("command outside variation window");
  dev_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick_r ##1 1'b1 |-> deviation_exceeded_flag_r ==
      ($past(abs_err) > 18'($past(deviation_level)) * 18'h00a))
    else $error("deviation flag disagrees with level");
  volt_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 output_voltage_r <= 16'($past(regulated_voltage_select)))
    else $error("output voltage above regulated voltage");
  sleep_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ASLEEP |=> frequency_command_r == 16'h0000 && output_stopped_r)
    else $error("output not stopped while asleep");
  wake_floor_a: assert property (@(posedge clock) disable iff (!rst_n)
    wake_eff >= sleep_chz && wake_eff <= `WAKE_MAX_CHZ)
    else $error("wake threshold outside its bounds");

  // Main scenarios.
  sleep_entry_c: cover property (@(posedge clock) disable iff (!rst_n)
    state_r == AWAKE ##1 state_r == ASLEEP);
  wake_up_c: cover property (@(posedge clock) disable iff (!rst_n)
    state_r == ASLEEP ##1 state_r == AWAKE);
  window_rise_c: cover property (@(posedge clock) disable iff (!rst_n)
    $rose(feedback_window_flag_r));
  read_nak_c: cover property (@(posedge clock) disable iff (!rst_n)
    $rose(bus_nak_r));
endmodule : drive_pid_process_controller

//--- testbench/process_sensor.sv
// Process sensor model: reports the measured process value back to the loop.
// Assumes the bench sets the process level; SLOW adds a cycle of transmitter lag.
`timescale 1ns/1ps
module process_sensor #(
  parameter bit SLOW = 1'b0
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [15:0] level,
  output logic [15:0]      feedback_r
);
  logic [15:0] stage_r;

  // A real transmitter never reports instantly, so the reading trails the process.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage_r    <= 16'h0000;
      feedback_r <= 16'h0000;
    end else begin
      stage_r    <= level;
      feedback_r <= SLOW ? stage_r : level;
    end
  end
endmodule : process_sensor

//--- testbench/drive_pid_process_controller_tb.sv
// Self-checking bench of the process loop: table of loop cases, then window, voltage, bus, sleep.
// Assumes the loop package and header are on the include path; the tick is cut to 20 cycles.
`timescale 1ns/1ps
module drive_pid_process_controller_tb;
  import loop_pkg::*;
  localparam int TC = 20;
  typedef struct packed {
    logic [1:0]  mode;
    logic [1:0]  rev;
    logic        inh;
    logic [7:0]  kp;
    logic [9:0]  rng;
    logic [15:0] tgt;
    logic [15:0] fb;
    logic [15:0] cmd;
    logic        dev;
  } row_t;
  // Gain in 0.1 steps, range in 0.1 %, values in 0.01 %; I and D terms are off.
  row_t rows [12] = '{
    '{2'h1, 2'h0, 1'h0, 8'h0a, 10'h000, 16'h1770, 16'h07d0, 16'h0fa0, 1'h1},
    '{2'h1, 2'h1, 1'h0, 8'h0a, 10'h000, 16'h07d0, 16'h1770, 16'h0fa0, 1'h1},
    '{2'h1, 2'h0, 1'h0, 8'h0a, 10'h000, 16'h07d0, 16'h1770, 16'h0000, 1'h1},
    '{2'h2, 2'h0, 1'h0, 8'h0a, 10'h000, 16'h07d0, 16'h1770, 16'h0fa0, 1'h1},
    '{2'h1, 2'h0, 1'h0, 8'h14, 10'h032, 16'h0bb8, 16'h03e8, 16'h0dac, 1'h1},
    '{2'h1, 2'h0, 1'h0, 8'h14, 10'h000, 16'h0bb8, 16'h03e8, 16'h0fa0, 1'h1},
    '{2'h2, 2'h0, 1'h0, 8'h14, 10'h032, 16'h0bb8, 16'h03e8, 16'h0fa0, 1'h1},
    '{2'h1, 2'h0, 1'h0, 8'h0a, 10'h000, 16'h1388, 16'h0fa0, 16'h03e8, 1'h0},
    '{2'h0, 2'h0, 1'h0, 8'h0a, 10'h000, 16'h0bb8, 16'h0bb8, 16'h0bb8, 1'h0},
    '{2'h1, 2'h0, 1'h1, 8'h0a, 10'h000, 16'h0bb8, 16'h0bb8, 16'h0bb8, 1'h0},
    '{2'h1, 2'h0, 1'h0, 8'h02, 10'h000, 16'h1770, 16'h03e8, 16'h03e8, 1'h1},
    '{2'h1, 2'h0, 1'h0, 8'hfa, 10'h000, 16'h0410, 16'h03e8, 16'h03e8, 1'h0}};
  logic [15:0] win_fb [4] = '{16'h0fa0, 16'h1770, 16'h0fa0, 16'h07d0};
  logic        win_on [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [6:0]  gain_in [5] = '{7'h32, 7'h0a, 7'h78, 7'h14, 7'h64};
  logic [23:0] volt_exp [5] = '{24'h64, 24'h28, 24'hc8, 24'h28, 24'hc8};
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic        loop_inhibit = 1'b0;
  logic [15:0] bus_addr = 16'h0006, bus_wdata = 16'h0000, target_preset = 16'h0000;
  logic [15:0] target_analog = 16'h0000, arith_result = 16'h0000, level = 16'h0000;
  logic [15:0] wake_threshold = 16'h1770, integral_time = 16'h0000;
  logic [9:0]  derivative_time = 10'h000;
  logic [7:0]  frequency_source_select = 8'h00, feedback_source_select = 8'h01;
  logic [7:0]  prop_gain = 8'h0a, sleep_delay = 8'h01;
  logic [1:0]  loop_enable_mode = 2'h0, reverse_action = 2'h0;
  logic [9:0]  variation_range = 10'h000, deviation_level = 10'h064;
  logic [13:0] feedback_scale = 14'h0064;
  logic [11:0] sleep_threshold = 12'h000;
  logic [6:0]  voltage_gain_pct = 7'h32;
  logic [8:0]  regulated_voltage_select = 9'h0c8;
  logic [15:0] analog_feedback_input, bus_rdata_r, command_pct_r;
  logic [15:0] frequency_command_r, output_voltage_r;
  logic [23:0] feedback_monitor_r;
  logic        bus_ack_r, bus_nak_r, output_stopped_r;
  logic        deviation_exceeded_flag_r, feedback_window_flag_r;
  int          error_cnt = 0;
  int          n_tests = 0;

  drive_pid_process_controller #(.TICK_CYCLES(TC)) u_drive_pid_process_controller (
    .clock, .rst_n, .bus_wr, .bus_rd, .bus_addr, .bus_wdata, .bus_rdata_r, .bus_ack_r,
    .bus_nak_r, .frequency_source_select, .target_preset, .target_analog, .arith_result,
    .analog_feedback_input, .feedback_source_select, .loop_enable_mode, .loop_inhibit,
    .prop_gain, .integral_time, .derivative_time, .feedback_scale,
    .reverse_action, .variation_range, .max_frequency(16'h2710), .sleep_threshold,
    .sleep_delay, .wake_threshold, .deviation_level, .window_off_level(10'h12c),
    .window_on_level(10'h1f4), .voltage_gain_pct, .regulated_voltage_select,
    .command_pct_r, .frequency_command_r, .output_stopped_r, .feedback_monitor_r,
    .deviation_exceeded_flag_r, .feedback_window_flag_r, .output_voltage_r);
  process_sensor u_process_sensor (.clock, .rst_n, .level, .feedback_r(analog_feedback_input));

  always #5 clock = ~clock;

  task automatic chk_w(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_w

  task automatic chk_b(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_b

  // Waits whole sample ticks, then steps off the edge so results have landed.
  task automatic ticks(input int n);
    repeat (n * TC) @(posedge clock);
    #1;
  endtask : ticks

  // One register access: strobe for one cycle, answer checked the cycle after it is taken.
  task automatic bus(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                     input logic ok, input logic [15:0] rd);
    @(posedge clock);
    bus_wr <= wr;
    bus_rd <= !wr;
    bus_addr <= addr;
    bus_wdata <= data;
    @(posedge clock);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    #1;
    chk_b("bus_ack_r", ok, bus_ack_r);
    chk_b("bus_nak_r", !ok, bus_nak_r);
    if (!wr) chk_w("bus_rdata_r", {8'h00, rd}, {8'h00, bus_rdata_r});
  endtask : bus

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // The run needs under 10000 cycles; far beyond that something hung.
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk_w("command_pct_r", 24'h0, {8'h00, command_pct_r});
    chk_w("output_voltage_r", 24'h0, {8'h00, output_voltage_r});
    foreach (rows[i]) begin
      @(posedge clock);
      loop_enable_mode <= rows[i].mode;
      reverse_action <= rows[i].rev;
      loop_inhibit <= rows[i].inh;
      prop_gain <= rows[i].kp;
      variation_range <= rows[i].rng;
      target_preset <= rows[i].tgt;
      level <= rows[i].fb;
      ticks(3);
      chk_w("command_pct_r", {8'h00, rows[i].cmd}, {8'h00, command_pct_r});
      chk_w("frequency_command_r", {8'h00, rows[i].cmd}, {8'h00, frequency_command_r});
      chk_w("feedback_monitor_r", {8'h00, rows[i].fb}, feedback_monitor_r);
      chk_b("deviation_flag", rows[i].dev, deviation_exceeded_flag_r);
    end
    // Between the off and on levels the flag keeps whatever it had.
    foreach (win_fb[k]) begin
      @(posedge clock);
      level <= win_fb[k];
      ticks(3);
      chk_b("feedback_window_flag_r", win_on[k], feedback_window_flag_r);
    end
    foreach (gain_in[k]) begin
      @(posedge clock);
      voltage_gain_pct <= gain_in[k];
      repeat (3) @(posedge clock);
      #1;
      chk_w("output_voltage_r", volt_exp[k], {8'h00, output_voltage_r});
    end
    @(posedge clock);
    loop_enable_mode <= 2'h2;
    prop_gain <= 8'h0a;
    target_preset <= 16'h2710;
    feedback_source_select <= 8'h02;
    feedback_scale <= 14'h00c8;
    bus(1'b1, 16'h0006, 16'h2ee0, 1'b1, 16'h0000);
    ticks(3);
    chk_w("command_pct_r", 24'h0, {8'h00, command_pct_r});
    // Full-scale feedback at a scale of 2.00 reads as 200 percent.
    chk_w("feedback_monitor_r", 24'h4e20, feedback_monitor_r);
    bus(1'b1, 16'h0006, 16'h07d0, 1'b1, 16'h0000);
    bus(1'b0, 16'h0006, 16'h0000, 1'b1, 16'h07d0);
    bus(1'b1, 16'h0007, 16'h0000, 1'b0, 16'h0000);
    ticks(3);
    chk_w("command_pct_r", 24'h1f40, {8'h00, command_pct_r});
    @(posedge clock);
    feedback_source_select <= 8'h01;
    bus(1'b0, 16'h0006, 16'h0000, 1'b0, 16'h0000);
    @(posedge clock);
    feedback_source_select <= 8'h10;
    arith_result <= 16'h0bb8;
    ticks(3);
    chk_w("command_pct_r", 24'h1b58, {8'h00, command_pct_r});
    @(posedge clock);
    frequency_source_select <= 8'h01;
    target_analog <= 16'h2328;
    ticks(3);
    chk_w("command_pct_r", 24'h1770, {8'h00, command_pct_r});
    @(posedge clock);
    frequency_source_select <= 8'h10;
    ticks(3);
    chk_w("command_pct_r", 24'h0, {8'h00, command_pct_r});
    // Sleep delay of 0.1 s is 100 ticks; a short excursion above restarts the count.
    @(posedge clock);
    frequency_source_select <= 8'h00;
    loop_inhibit <= 1'b1;
    target_preset <= 16'h0fa0;
    sleep_threshold <= 12'h1f4;
    ticks(60);
    @(posedge clock);
    target_preset <= 16'h1f40;
    ticks(5);
    @(posedge clock);
    target_preset <= 16'h0fa0;
    ticks(90);
    chk_b("output_stopped_r", 1'b0, output_stopped_r);
    ticks(15);
    chk_b("output_stopped_r", 1'b1, output_stopped_r);
    chk_w("frequency_command_r", 24'h0, {8'h00, frequency_command_r});
    @(posedge clock);
    target_preset <= 16'h1b58;
    ticks(90);
    chk_b("output_stopped_r", 1'b1, output_stopped_r);
    ticks(15);
    chk_b("output_stopped_r", 1'b0, output_stopped_r);
    chk_w("frequency_command_r", 24'h1b58, {8'h00, frequency_command_r});
    // A target step kicks the derivative term to full scale for exactly one tick.
    @(posedge clock);
    loop_inhibit <= 1'b0;
    loop_enable_mode <= 2'h1;
    derivative_time <= 10'h001;
    feedback_source_select <= 8'h01;
    target_preset <= 16'h07d0;
    level <= 16'h07d0;
    ticks(3);
    @(posedge clock);
    target_preset <= 16'h0bb8;
    ticks(1);
    chk_w("command_pct_r", 24'h2710, {8'h00, command_pct_r});
    ticks(2);
    chk_w("command_pct_r", 24'h03e8, {8'h00, command_pct_r});
    // The integral climbs above the bare P term, and a negative sum still gives zero.
    @(posedge clock);
    derivative_time <= 10'h000;
    integral_time <= 16'h0001;
    ticks(20);
    chk_b("integral_ramp", 1'b1, command_pct_r > 16'h03e8 && command_pct_r < 16'h07d0);
    @(posedge clock);
    target_preset <= 16'h03e8;
    ticks(40);
    chk_w("command_pct_r", 24'h0, {8'h00, command_pct_r});
    stop_test();
  end
endmodule : drive_pid_process_controller_tb
